// >>> rtl/sar_adc_control.sv
// Control logic of a 10-bit successive-approximation converter.
// Assumes an AXI4-Lite master, an analog front end answering comparator
// decisions each bit period, and a system sleep level from the core.
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps

// Overview of operation
// - Clock select 000/100/001/101/010/110 divide 2..64; x11 uses RC clock.
// - A full conversion takes exactly eleven bit periods.
// - Reference bits pick external pins, otherwise ground and supply.
// - Channel select field routes inputs zero to seven to sample-and-hold.
// - Done flag sets after every completed conversion regardless of enable.
// - Asleep with interrupt enabled, completion raises a wake request.
// - Justify bit one gives right, zero gives left justification.
// - Left: result bits nine to two go to high byte.
// - Right: bits nine, eight in high one, zero; low eight in low.
// - Left: result bits one, zero go to low byte bits seven, six.
// - Converter off holds the block idle; setting on enables it.
// - Writing go starts conversion; go reads one while converting.
// - Completion clears go, sets done flag, loads result pair.
// - Clearing go early aborts; result registers keep old value.
// - After abort wait two bit periods, then acquire selected channel.
// - Reset restores registers, turns converter off, ends any conversion.
// - With RC clock, conversion starts one instruction cycle after go.
// - Asleep on RC clock, interrupt off: power down after completion.
// - Sleep on a divided clock mid-conversion aborts and powers down, on stays set.
// - Compare-unit trigger pulse sets go like a software write.
module sar_adc_control (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // System
  input wire logic sleep_active,
  input wire logic trigger_pulse,
  input wire logic rc_clk_tick,
  output logic wake_request,
  // Analog front end
  input wire logic comparator_high,
  output sar_adc_pkg::analog_ctrl_t analog_ctrl
);

  typedef enum logic [1:0] {IDLE, START_WAIT, CONVERT, ABORT_WAIT} conv_state_t;

  conv_state_t state_q;
  logic [7:0] ctrl_q;
  logic [2:0] clksel_q;
  logic [7:0] res_high_q;
  logic [7:0] res_low_q;
  logic done_flag_q;
  logic irq_en_q;
  logic powered_down_q;
  logic [3:0] period_cnt_q;
  logic [3:0] start_cnt_q;
  logic [9:0] sar_q;
  logic [9:0] bit_mask_q;
  logic period_tick;
  logic use_rc;
  logic on_en;

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_fire;
  logic rd_fire;
  logic wr_hit;
  logic [31:0] rd_word;
  logic rd_hit;

  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign wr_hit = (aw_addr_q == sar_adc_pkg::CTRL_MAIN_ADDR)
               || (aw_addr_q == sar_adc_pkg::CLK_SEL_ADDR)
               || (aw_addr_q == sar_adc_pkg::RES_HIGH_ADDR)
               || (aw_addr_q == sar_adc_pkg::RES_LOW_ADDR)
               || (aw_addr_q == sar_adc_pkg::STATUS_ADDR);

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else begin
      if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
      s_axi_awready <= !aw_held_q && !s_axi_awready;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      w_held_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else begin
      if (wr_fire) begin
        w_held_q <= 1'b0;
      end
      s_axi_wready <= !w_held_q && !s_axi_wready;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sar_adc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? sar_adc_pkg::RESP_OKAY : sar_adc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr)
      sar_adc_pkg::CTRL_MAIN_ADDR: rd_word[7:0] = ctrl_q;
      sar_adc_pkg::CLK_SEL_ADDR: rd_word[6:4] = clksel_q;
      sar_adc_pkg::RES_HIGH_ADDR: rd_word[7:0] = res_high_q;
      sar_adc_pkg::RES_LOW_ADDR: rd_word[7:0] = res_low_q;
      sar_adc_pkg::STATUS_ADDR: begin
        rd_word[sar_adc_pkg::DONE_FLAG_BIT] = done_flag_q;
        rd_word[sar_adc_pkg::IRQ_EN_BIT] = irq_en_q;
        rd_word[sar_adc_pkg::SLEEP_BIT] = sleep_active;
        rd_word[sar_adc_pkg::POWERED_BIT] = !powered_down_q;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= sar_adc_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? sar_adc_pkg::RESP_OKAY : sar_adc_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= !s_axi_arready;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  logic wr_ctrl;
  logic wr_status;
  logic go_written;
  logic go_cleared;
  logic start_req;
  logic complete;
  logic abort;
  logic sleep_abort;

  assign wr_ctrl = wr_fire && w_strb_q[0] && (aw_addr_q == sar_adc_pkg::CTRL_MAIN_ADDR);
  assign wr_status = wr_fire && w_strb_q[0] && (aw_addr_q == sar_adc_pkg::STATUS_ADDR);
  assign go_written = wr_ctrl && w_data_q[sar_adc_pkg::GO_BIT] && !ctrl_q[sar_adc_pkg::GO_BIT];
  assign go_cleared = wr_ctrl && !w_data_q[sar_adc_pkg::GO_BIT];
  assign use_rc = (clksel_q[1:0] == sar_adc_pkg::RC_CODE_LOW);
  assign on_en = ctrl_q[sar_adc_pkg::ON_BIT];
  // Go only acts when the converter was already on before this write
  assign start_req = on_en && !powered_down_q && (go_written || trigger_pulse);
  assign complete = (state_q == CONVERT) && period_tick
                 && (period_cnt_q == sar_adc_pkg::CONV_PERIODS - 4'h1);
  assign sleep_abort = sleep_active && !use_rc && (state_q != IDLE);
  assign abort = ((state_q == CONVERT) || (state_q == START_WAIT))
              && (go_cleared || sleep_abort) && !complete;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ctrl_q <= sar_adc_pkg::CTRL_MAIN_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= {w_data_q[7:2], ctrl_q[sar_adc_pkg::GO_BIT] && w_data_q[1], w_data_q[0]};
      end
      if (!on_en && !(wr_ctrl && w_data_q[0])) begin
        ctrl_q[sar_adc_pkg::GO_BIT] <= 1'b0;
      end else if (start_req) begin
        ctrl_q[sar_adc_pkg::GO_BIT] <= 1'b1;
      end else if (complete || sleep_abort) begin
        ctrl_q[sar_adc_pkg::GO_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      clksel_q <= sar_adc_pkg::CLK_SEL_RESET[6:4];
    end else if (wr_fire && w_strb_q[0] && aw_addr_q == sar_adc_pkg::CLK_SEL_ADDR) begin
      clksel_q <= w_data_q[6:4];
    end
  end

  // Set wins over a clearing write in the same cycle
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      done_flag_q <= 1'b0;
      irq_en_q <= 1'b0;
    end else begin
      if (wr_status) begin
        irq_en_q <= w_data_q[sar_adc_pkg::IRQ_EN_BIT];
      end
      if (complete) begin
        done_flag_q <= 1'b1;
      end else if (wr_status) begin
        done_flag_q <= w_data_q[sar_adc_pkg::DONE_FLAG_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  sar_period_gen u_period (
    .core_clk(core_clk),
    .resetn(resetn),
    .run((state_q == CONVERT && !abort) || state_q == ABORT_WAIT), // Whole periods after abort
    .clock_divider_select(clksel_q),
    .rc_clk_tick(rc_clk_tick),
    .period_tick(period_tick)
  );

  always_ff @(posedge core_clk) begin
    if (!resetn || !on_en) begin
      state_q <= IDLE;
      period_cnt_q <= 4'h0;
      start_cnt_q <= 4'h0;
    end else begin
      unique case (state_q)
        IDLE: begin
          period_cnt_q <= 4'h0;
          start_cnt_q <= 4'h0;
          if (start_req) begin
            state_q <= use_rc ? START_WAIT : CONVERT;
          end
        end
        START_WAIT: begin
          start_cnt_q <= start_cnt_q + 4'h1;
          if (abort) begin
            state_q <= ABORT_WAIT;
          end else if (start_cnt_q == sar_adc_pkg::INSTR_CYCLES - 4'h1) begin
            state_q <= CONVERT;
          end
        end
        CONVERT: begin
          if (abort) begin
            state_q <= ABORT_WAIT;
            period_cnt_q <= 4'h0;
          end else if (complete) begin
            state_q <= IDLE;
          end else if (period_tick) begin
            period_cnt_q <= period_cnt_q + 4'h1;
          end
        end
        ABORT_WAIT: begin
          if (period_tick) begin
            period_cnt_q <= period_cnt_q + 4'h1;
            if (period_cnt_q == sar_adc_pkg::ABORT_PERIODS - 4'h1) begin
              state_q <= IDLE;
            end
          end
        end
      endcase
    end
  end

  // Period 0 samples; periods 1..10 resolve one bit each, MSB first
  always_ff @(posedge core_clk) begin
    if (!resetn || state_q != CONVERT) begin
      sar_q <= 10'h000;
      bit_mask_q <= 10'h200;
    end else if (period_tick && period_cnt_q != 4'h0) begin
      if (comparator_high) begin
        sar_q <= sar_q | bit_mask_q;
      end
      bit_mask_q <= bit_mask_q >> 1;
    end
  end

  // ----------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------
  logic [9:0] final_val;
  assign final_val = comparator_high ? (sar_q | bit_mask_q) : sar_q;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      res_high_q <= sar_adc_pkg::RESULT_RESET;
      res_low_q <= sar_adc_pkg::RESULT_RESET;
    end else if (complete) begin
      if (ctrl_q[sar_adc_pkg::JUST_BIT]) begin
        res_high_q <= {6'h00, final_val[9:8]};
        res_low_q <= final_val[7:0];
      end else begin
        res_high_q <= final_val[9:2];
        res_low_q <= {final_val[1:0], 6'h00};
      end
    end else if (wr_fire && w_strb_q[0] && aw_addr_q == sar_adc_pkg::RES_HIGH_ADDR) begin
      res_high_q <= w_data_q[7:0];
    end else if (wr_fire && w_strb_q[0] && aw_addr_q == sar_adc_pkg::RES_LOW_ADDR) begin
      res_low_q <= w_data_q[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Sleep, power and analog drive
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      powered_down_q <= 1'b0;
      wake_request <= 1'b0;
    end else begin
      wake_request <= complete && sleep_active && irq_en_q;
      if (!sleep_active) begin
        powered_down_q <= 1'b0;
      end else if (complete && use_rc && !irq_en_q) begin
        powered_down_q <= 1'b1;
      end else if (sleep_abort) begin
        powered_down_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      analog_ctrl <= '0;
    end else begin
      analog_ctrl.powered <= on_en && !powered_down_q;
      analog_ctrl.sample <= on_en && !powered_down_q && (state_q == IDLE);
      analog_ctrl.channel <= ctrl_q[sar_adc_pkg::CHS_LSB +: 3];
      analog_ctrl.pos_ext <= ctrl_q[sar_adc_pkg::POS_REF_BIT];
      analog_ctrl.neg_ext <= ctrl_q[sar_adc_pkg::NEG_REF_BIT];
      analog_ctrl.trial <= sar_q | bit_mask_q;
    end
  end

endmodule

// >>> common/sar_adc_pkg.sv
// Package for the converter control block: register map, fields, timing.
// Assumes a 32-bit AXI4-Lite register bus and a 250 MHz core clock.
package sar_adc_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_MAIN_ADDR = 8'h00;
  localparam logic [7:0] CLK_SEL_ADDR = 8'h04;
  localparam logic [7:0] RES_HIGH_ADDR = 8'h08;
  localparam logic [7:0] RES_LOW_ADDR = 8'h0C;
  localparam logic [7:0] STATUS_ADDR = 8'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ON_BIT = 0;
  localparam int GO_BIT = 1;
  localparam int CHS_LSB = 2;
  localparam int POS_REF_BIT = 5;
  localparam int NEG_REF_BIT = 6;
  localparam int JUST_BIT = 7;
  localparam int CLKSEL_LSB = 4;
  localparam int DONE_FLAG_BIT = 0;
  localparam int IRQ_EN_BIT = 1;
  localparam int SLEEP_BIT = 2;
  localparam int POWERED_BIT = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_MAIN_RESET = 8'h00;
  localparam logic [7:0] CLK_SEL_RESET = 8'h00;
  localparam logic [7:0] RESULT_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Clock select codes and sequencing counts
  // ----------------------------------------------------------------
  localparam logic [2:0] DIV2_CODE = 3'h0;
  localparam logic [2:0] DIV4_CODE = 3'h4;
  localparam logic [2:0] DIV8_CODE = 3'h1;
  localparam logic [2:0] DIV16_CODE = 3'h5;
  localparam logic [2:0] DIV32_CODE = 3'h2;
  localparam logic [2:0] DIV64_CODE = 3'h6;
  localparam logic [1:0] RC_CODE_LOW = 2'h3;
  localparam logic [3:0] CONV_PERIODS = 4'hB;
  localparam logic [3:0] ABORT_PERIODS = 4'h2;
  // One instruction cycle is four core clocks
  localparam logic [3:0] INSTR_CYCLES = 4'h4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Analog-side controls
  typedef struct packed {
    logic powered;
    logic sample;
    logic [2:0] channel;
    logic pos_ext;
    logic neg_ext;
    logic [9:0] trial;
  } analog_ctrl_t;

endpackage

// >>> rtl/sar_period_gen.sv
// Bit-period tick generator for the converter.
// Assumes rc_clk_tick is a one-cycle pulse synchronous to core_clk.
`timescale 1ns/1ps
module sar_period_gen (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Control
  input wire logic run,
  input wire logic [2:0] clock_divider_select,
  input wire logic rc_clk_tick,
  // Tick out
  output logic period_tick
);

  logic [5:0] div_q;
  logic [5:0] limit;
  logic use_rc;

  always_comb begin
    use_rc = (clock_divider_select[1:0] == sar_adc_pkg::RC_CODE_LOW);
    unique case (clock_divider_select)
      sar_adc_pkg::DIV2_CODE: limit = 6'h01;
      sar_adc_pkg::DIV4_CODE: limit = 6'h03;
      sar_adc_pkg::DIV8_CODE: limit = 6'h07;
      sar_adc_pkg::DIV16_CODE: limit = 6'h0F;
      sar_adc_pkg::DIV32_CODE: limit = 6'h1F;
      sar_adc_pkg::DIV64_CODE: limit = 6'h3F;
      default: limit = 6'h00;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn || !run) begin
      div_q <= 6'h00;
      period_tick <= 1'b0;
    end else if (use_rc) begin
      div_q <= 6'h00;
      period_tick <= rc_clk_tick;
    end else if (div_q == limit) begin
      div_q <= 6'h00;
      period_tick <= 1'b1;
    end else begin
      div_q <= div_q + 6'h01;
      period_tick <= 1'b0;
    end
  end

endmodule

// >>> sim/sar_adc_control_properties.sv
// Port checker for the converter control block.
// Assumes it is bound to sar_adc_control and sees only its ports.
`timescale 1ns/1ps
module sar_adc_control_props (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Register bus
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // System and analog side
  input wire logic sleep_active,
  input wire logic wake_request,
  input sar_adc_pkg::analog_ctrl_t analog_ctrl
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  // --------------------------------------------------------------
  // Steps
  // --------------------------------------------------------------
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence rd_unmapped;
    rd_taken ##0 (s_axi_araddr > 8'h10);
  endsequence
  sequence bit_phase;
    analog_ctrl.powered && $fell(analog_ctrl.sample);
  endsequence
  a_reset_quiet: assert property ($rose(resetn) |->
    !s_axi_bvalid && !s_axi_rvalid && !wake_request && !analog_ctrl.powered)
    else $error("outputs active after reset");
  a_wake_pulse: assert property (wake_request |=> !wake_request)
    else $error("wake request longer than one cycle");
  a_wake_asleep: assert property (wake_request |-> $past(sleep_active))
    else $error("wake request while awake");
  a_msb_first: assert property (bit_phase |-> ##[0:1] analog_ctrl.trial == 10'h200)
    else $error("first trial is not the top bit");
  a_unmapped_err: assert property (rd_unmapped |=>
    s_axi_rvalid && s_axi_rresp == sar_adc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_rvalid_cause: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
    else $error("read answer without request");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped early");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
endmodule

bind sar_adc_control sar_adc_control_props u_props (
  .core_clk, .resetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .sleep_active, .wake_request, .analog_ctrl
);

// >>> sim/analog_front_model.sv
// Sample-and-hold and comparator model on the analog side.
// Assumes the trial word is held steady through each bit period.
`timescale 1ns/1ps
module analog_front_model (
  // Clock
  input wire logic core_clk,
  // Controls and decision
  input sar_adc_pkg::analog_ctrl_t analog_ctrl,
  output logic comparator_high
);
  logic [9:0] level;
  logic flip_q = 1'b0;
  // Each input carries its own level
  assign level = {analog_ctrl.channel, 7'h2D};
  always_ff @(posedge core_clk) begin
    flip_q <= !flip_q;
  end
  // Powered down gives no steady decision
  assign comparator_high = analog_ctrl.powered ? (analog_ctrl.trial <= level) : flip_q;
endmodule

// >>> sim/sar_adc_control_tb_top.sv
// Testbench for the converter control block.
// Assumes the analog model and the bound port checker beside it.
`timescale 1ns/1ps
module sar_adc_control_tb_top;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic sleep_active = 1'b0;
  logic trigger_pulse = 1'b0;
  logic rc_clk_tick = 1'b0;
  logic wake_request;
  logic comparator_high;
  sar_adc_pkg::analog_ctrl_t analog_ctrl;
  logic [1:0] resp;
  logic [31:0] rv;
  logic [4:0] rc_n = 5'h00;
  int low_n = 0;
  int tick_n = 0;
  int wake_n = 0;
  int bad_count = 0;
  int compares = 0;
  localparam logic [2:0] CODES [8] = '{sar_adc_pkg::DIV2_CODE, sar_adc_pkg::DIV4_CODE,
    sar_adc_pkg::DIV8_CODE, sar_adc_pkg::DIV16_CODE, sar_adc_pkg::DIV32_CODE,
    sar_adc_pkg::DIV64_CODE, 3'h3, 3'h7};
  localparam int PER [8] = '{2, 4, 8, 16, 32, 64, 20, 20};
  localparam logic [7:0] CT = sar_adc_pkg::CTRL_MAIN_ADDR;
  localparam logic [7:0] CK = sar_adc_pkg::CLK_SEL_ADDR;
  localparam logic [7:0] ST = sar_adc_pkg::STATUS_ADDR;

  sar_adc_control DUT (
    .core_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sleep_active, .trigger_pulse,
    .rc_clk_tick, .wake_request, .comparator_high, .analog_ctrl
  );
  analog_front_model FRONT (.core_clk, .analog_ctrl, .comparator_high);

  initial begin
    forever #2 core_clk = ~core_clk;
  end
  // --------------------------------------------------------------
  // RC tick every 20 clocks, restarted while sampling, and monitors
  // --------------------------------------------------------------
  always @(posedge core_clk) begin
    rc_n <= (rc_n == 5'h13 || analog_ctrl.sample === 1'b1) ? 5'h00 : rc_n + 5'h01;
    rc_clk_tick <= (rc_n == 5'h13);
    if (analog_ctrl.powered === 1'b1 && analog_ctrl.sample === 1'b0) begin
      low_n <= low_n + 1;
      tick_n <= tick_n + int'(rc_clk_tick);
    end
    if (wake_request === 1'b1) wake_n <= wake_n + 1;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rv = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
                       input string n);
    rd(a);
    chk(n, {24'h0, e}, rv & {24'h0, m});
  endtask
  task automatic wait_go;
    do rd(CT); while (rv[1] !== 1'b0);
  endtask
  task automatic start(input logic [2:0] code, input logic [7:0] c);
    wr(ST, 32'h0);
    wr(CK, {25'h0, code, 4'h0});
    wr(CT, {24'h0, c});
    low_n = 0;
    tick_n = 0;
    wr(CT, {24'h0, c | 8'h02});
  endtask
  task automatic conv(input logic [2:0] code, input int per, input logic [2:0] ch,
                      input logic j);
    logic [9:0] r;
    r = {ch, 7'h2D};
    start(code, {j, ch[1], ch[0], ch, 2'b01});
    chk("channel", {29'h0, ch}, {29'h0, analog_ctrl.channel});
    chk("refs", {30'h0, ch[1:0]}, {30'h0, analog_ctrl.neg_ext, analog_ctrl.pos_ext});
    rdchk(CT, 8'h02, 8'h02, "go_busy");
    wait_go();
    chk("periods", per == 20 ? 11 : 11 * per + 1, per == 20 ? tick_n : low_n);
    rdchk(ST, 8'h01, 8'h01, "done");
    if (j) begin
      rdchk(sar_adc_pkg::RES_HIGH_ADDR, 8'h03, {6'h0, r[9:8]}, "res_h");
      rdchk(sar_adc_pkg::RES_LOW_ADDR, 8'hFF, r[7:0], "res_l");
    end else begin
      rdchk(sar_adc_pkg::RES_HIGH_ADDR, 8'hFF, r[9:2], "res_h");
      rdchk(sar_adc_pkg::RES_LOW_ADDR, 8'hC0, {r[1:0], 6'h0}, "res_l");
    end
  endtask
  task automatic abort_run;
    logic [31:0] h;
    int n;
    rd(sar_adc_pkg::RES_HIGH_ADDR);
    h = rv;
    start(sar_adc_pkg::DIV64_CODE, 8'h01);
    repeat (200) @(posedge core_clk);
    wr(CT, 32'h1);
    n = 0;
    while (analog_ctrl.sample !== 1'b1 && n < 300) begin
      @(posedge core_clk);
      n++;
    end
    chk("abort_gap", 2 * 64 + 1, n);
    rdchk(sar_adc_pkg::RES_HIGH_ADDR, 8'hFF, h[7:0], "res_kept");
    rdchk(ST, 8'h01, 8'h00, "no_done");
  endtask
  task automatic trig_run;
    wr(ST, 32'h0);
    wr(CT, 32'h0);
    trigger_pulse <= 1'b1;
    @(posedge core_clk);
    trigger_pulse <= 1'b0;
    repeat (40) @(posedge core_clk);
    rdchk(CT, 8'h03, 8'h00, "off_idle");
    rdchk(ST, 8'h01, 8'h00, "off_done");
    wr(CT, 32'h3);
    rdchk(CT, 8'h03, 8'h01, "on_first");
    trigger_pulse <= 1'b1;
    @(posedge core_clk);
    trigger_pulse <= 1'b0;
    rdchk(CT, 8'h02, 8'h02, "trig_go");
    wait_go();
    rdchk(ST, 8'h01, 8'h01, "trig_done");
  endtask
  task automatic sleep_div;
    start(sar_adc_pkg::DIV64_CODE, 8'h01);
    repeat (100) @(posedge core_clk);
    sleep_active <= 1'b1;
    repeat (10) @(posedge core_clk);
    chk("pwr_down", 32'h0, {31'h0, analog_ctrl.powered});
    rdchk(CT, 8'h01, 8'h01, "on_kept");
    repeat (800) @(posedge core_clk);
    rdchk(ST, 8'h01, 8'h00, "aborted");
    sleep_active <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic sleep_rc(input logic irq);
    wr(ST, {30'h0, irq, 1'b0});
    wr(CK, 32'h30);
    wr(CT, 32'h1);
    wake_n = 0;
    wr(CT, 32'h3);
    sleep_active <= 1'b1;
    wait_go();
    repeat (4) @(posedge core_clk);
    chk("wake", {31'h0, irq}, wake_n);
    if (!irq) chk("rc_pwr", 32'h0, {31'h0, analog_ctrl.powered});
    rdchk(CT, 8'h01, 8'h01, "rc_on");
    rdchk(ST, 8'h01, 8'h01, "rc_done");
    sleep_active <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic reset_run;
    start(sar_adc_pkg::DIV64_CODE, 8'h01);
    repeat (20) @(posedge core_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("rst_pwr", 32'h0, {31'h0, analog_ctrl.powered});
    rdchk(CT, 8'hFF, sar_adc_pkg::CTRL_MAIN_RESET, "rst_ctrl");
    rdchk(CK, 8'hFF, sar_adc_pkg::CLK_SEL_RESET, "rst_clk");
  endtask
  task automatic final_report;
    if (bad_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge core_clk);
    bad_count++;
    final_report();
  end
  initial begin
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge core_clk);
    rdchk(CT, 8'hFF, sar_adc_pkg::CTRL_MAIN_RESET, "ctrl_init");
    rdchk(sar_adc_pkg::RES_HIGH_ADDR, 8'hFF, sar_adc_pkg::RESULT_RESET, "res_init");
    rd(8'h20);
    chk("unmapped", {30'h0, sar_adc_pkg::RESP_SLVERR}, {30'h0, resp});
    for (int i = 0; i < 8; i++) conv(CODES[i], PER[i], i[2:0], i[0]);
    abort_run();
    trig_run();
    sleep_div();
    sleep_rc(1'b1);
    sleep_rc(1'b0);
    reset_run();
    final_report();
  end
endmodule
